// ===== core/aqf_framer.sv
// Serial command and transmit request frame interpreter with AHB-Lite registers
//
// Overview of operation
// - Queued frame with a value stores it pending; applied on immediate frame or apply.
// - Queued frame without value is a query, answered at once, never queued.
// - Queued parameter frames are answered with a 0x88 response.
// - A queued serial rate change leaves the active rate until applied.
// - Offset 4 is the host's identifier; zero suppresses every response.
// - Bytes from offset 7 to checksum are the value; none means read.
// - One, two or four byte zero-padded values mean the same number.
// - Type 0x10 sends its payload as one network packet.
// - Offsets 5 to 12 hold the 64-bit destination, most significant first.
// - Destination 0x000000000000FFFF is a broadcast to all nodes.
// - Zero address with 0xFFFE, or coordinator address with 0x0000, reaches coordinator.
// - Net address 0xFFFE means unknown or broadcast; the device resolves it.
// - Unknown net address: the found address goes in the 0x8B status.
// - Radius zero selects configured maximum hops; nonzero up to maximum used directly.
// - Radius only matters for broadcasts; unicast ignores it.
// - Option 0x01 no retries, 0x20 encryption if enabled, 0x40 extended timeout.
// - Encryption lowers the allowed payload by four bytes.
// - Extended timeout is recorded for that destination and used.
// - Payload from offset 17 goes out unchanged, within the payload maximum.
// - Frames start with 0x7E and a two-byte length, both outside the checksum.
// - Checksum is 0xFF minus the byte sum; verified on every frame of nonzero length.
`timescale 1ns/100ps
`default_nettype none
module aqf_framer import aqf_pkg::*; #(
  parameter int PAY_DEPTH = 256,
  parameter logic [63:0] COORD_RST = 64'h0000_0000_0000_0000
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  output logic pkt_valid,
  output logic [7:0] pkt_data,
  output logic pkt_last,
  input wire logic pkt_ready,
  output logic [15:0] pkt_len,
  output logic [63:0] pkt_dest64,
  output logic [15:0] pkt_net16,
  output logic pkt_bcast,
  output logic pkt_coord,
  output logic pkt_resolve,
  output logic [7:0] pkt_radius,
  output logic pkt_no_retry,
  output logic pkt_encrypt,
  output logic pkt_ext_timeout,
  input wire logic tx_done,
  input wire logic [7:0] tx_status,
  input wire logic [15:0] tx_net16,
  output logic resp_valid,
  input wire logic resp_ready,
  output logic [7:0] resp_type,
  output logic [7:0] resp_id,
  output logic [15:0] resp_name,
  output logic [7:0] resp_status,
  output logic [31:0] resp_value,
  output logic [15:0] resp_net16,
  output logic [7:0] serial_rate
);
  localparam int PW = $clog2(PAY_DEPTH);
  localparam logic [PW:0] PAY_FULL = (PW+1)'(PAY_DEPTH);

  aqf_state_t state_reg;
  logic [15:0] len_reg, ofs_reg;
  logic [7:0] sum_reg, type_reg, id_reg, radius_reg, opts_reg;
  logic [15:0] name_reg, net_reg;
  logic [63:0] dest_reg, coord_reg, ext_dest_reg;
  logic [31:0] val_reg;
  logic [2:0] vcnt_reg;
  logic [PW:0] pcnt_reg, rd_reg;
  logic [7:0] mem [PAY_DEPTH];
  logic [7:0] rate_act_reg, rate_pend_reg, hops_act_reg, hops_pend_reg;
  logic ee_act_reg, ee_pend_reg, rx_en_reg;
  logic [15:0] maxpay_reg, good_cnt_reg, bad_cnt_reg;
  logic rx_take, has_val, is_cmd, is_bcast, is_coord, enc_req, too_big, exec_cmd;
  logic [15:0] pay_limit;
  logic [7:0] cmd_status;
  logic [31:0] qry_val;
  logic wr_pend_reg;
  logic [7:0] waddr_reg;
  logic [31:0] rd_mux;

  // ****
  // Frame decode
  // ****
  // Receiver stalls while a frame is executed, sent or answered
  assign rx_ready = ce && rx_en_reg && (state_reg inside {S_IDLE, S_LENH, S_LENL, S_BODY, S_CHK});
  assign rx_take = rx_valid && rx_ready;
  assign has_val = (vcnt_reg != 3'h0);
  assign is_cmd = (type_reg == T_CMD) || (type_reg == T_QCMD);
  assign is_bcast = (dest_reg == ADDR_BCAST);
  assign is_coord = ((dest_reg == ADDR_ZERO) && (net_reg == NET_UNKNOWN))
                    || ((dest_reg == coord_reg) && (net_reg == NET_COORD));
  assign enc_req = opts_reg[OPT_ENC] && ee_act_reg;
  assign pay_limit = enc_req ? (maxpay_reg - ENC_OVERHEAD) : maxpay_reg;
  assign too_big = (pcnt_reg == PAY_FULL) || (16'(pcnt_reg) > pay_limit);
  assign exec_cmd = (state_reg == S_EXEC) && is_cmd && (cmd_status == ST_OK);

  always_comb begin
    cmd_status = ST_OK;
    qry_val = 32'h0000_0000;
    unique case (name_reg)
      NM_RATE: qry_val = {24'h00_0000, rate_pend_reg};
      NM_HOPS: qry_val = {24'h00_0000, hops_pend_reg};
      NM_ENC: qry_val = {31'h0000_0000, ee_pend_reg};
      NM_PAYLOAD: qry_val = {16'h0000, maxpay_reg};
      NM_APPLY: qry_val = 32'h0000_0000;
      default: cmd_status = ST_BADCMD;
    endcase
    // Any of the accepted widths yields the same shifted-in number
    if (has_val && cmd_status == ST_OK) begin
      if (vcnt_reg > VAL_MAX_BYTES || name_reg == NM_PAYLOAD) begin
        cmd_status = ST_BADPARM;
      end else if (val_reg[31:8] != 24'h00_0000) begin
        cmd_status = ST_BADPARM;
      end else if (name_reg == NM_ENC && val_reg[7:1] != 7'h00) begin
        cmd_status = ST_BADPARM;
      end
    end
  end

  // ****
  // Frame sequencer
  // ****
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= S_IDLE;
      len_reg <= 16'h0000;
      ofs_reg <= 16'h0000;
      sum_reg <= 8'h00;
      rd_reg <= '0;
    end else if (ce) begin
      unique case (state_reg)
        S_IDLE: if (rx_take && rx_data == DELIM) begin
          state_reg <= S_LENH;
        end
        S_LENH: if (rx_take) begin
          len_reg[15:8] <= rx_data;
          state_reg <= S_LENL;
        end
        S_LENL: if (rx_take) begin
          len_reg[7:0] <= rx_data;
          ofs_reg <= OFS_TYPE;
          sum_reg <= 8'h00;
          state_reg <= ({len_reg[15:8], rx_data} == 16'h0000) ? S_IDLE : S_BODY;
        end
        S_BODY: if (rx_take) begin
          sum_reg <= sum_reg + rx_data;
          ofs_reg <= ofs_reg + 16'h0001;
          if (ofs_reg == len_reg + LEN_TO_LAST) begin
            state_reg <= S_CHK;
          end
        end
        // Bad frames leave no trace beyond the error count
        S_CHK: if (rx_take) begin
          state_reg <= (8'(sum_reg + rx_data) == CHK_GOOD) ? S_EXEC : S_IDLE;
        end
        S_EXEC: begin
          rd_reg <= '0;
          if (type_reg == T_TXREQ && !too_big) begin
            state_reg <= S_SEND;
          end else if (type_reg == T_TXREQ || is_cmd) begin
            state_reg <= (id_reg != 8'h00) ? S_RESP : S_IDLE;
          end else begin
            state_reg <= S_IDLE;
          end
        end
        S_SEND: if (pkt_ready) begin
          rd_reg <= rd_reg + 1'b1;
          if (pkt_last) begin
            state_reg <= S_WAIT;
          end
        end
        S_WAIT: if (tx_done) begin
          state_reg <= (id_reg != 8'h00) ? S_RESP : S_IDLE;
        end
        S_RESP: if (resp_ready) begin
          state_reg <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // Field capture by byte offset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      type_reg <= 8'h00;
      id_reg <= 8'h00;
      name_reg <= 16'h0000;
      dest_reg <= 64'h0;
      net_reg <= 16'h0000;
      radius_reg <= 8'h00;
      opts_reg <= 8'h00;
      val_reg <= 32'h0000_0000;
      vcnt_reg <= 3'h0;
      pcnt_reg <= '0;
    end else if (ce && rx_take) begin
      if (state_reg == S_LENL) begin
        vcnt_reg <= 3'h0;
        pcnt_reg <= '0;
        val_reg <= 32'h0000_0000;
      end else if (state_reg == S_BODY) begin
        if (ofs_reg == OFS_TYPE) type_reg <= rx_data;
        if (ofs_reg == OFS_ID) id_reg <= rx_data;
        if (ofs_reg == OFS_NAME || ofs_reg == OFS_NAME_LO) begin
          name_reg <= {name_reg[7:0], rx_data};
        end
        if (ofs_reg >= OFS_DEST && ofs_reg <= OFS_DEST_LO) begin
          dest_reg <= {dest_reg[55:0], rx_data};
        end
        if (ofs_reg == OFS_NET || ofs_reg == OFS_NET_LO) begin
          net_reg <= {net_reg[7:0], rx_data};
        end
        if (ofs_reg == OFS_RADIUS) radius_reg <= rx_data;
        if (ofs_reg == OFS_OPTS) opts_reg <= rx_data;
        if (is_cmd && ofs_reg >= OFS_VAL) begin
          val_reg <= {val_reg[23:0], rx_data};
          if (vcnt_reg <= VAL_MAX_BYTES) vcnt_reg <= vcnt_reg + 3'h1;
        end
        if (type_reg == T_TXREQ && ofs_reg >= OFS_PAY && pcnt_reg != PAY_FULL) begin
          pcnt_reg <= pcnt_reg + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge hclk) begin
    if (ce && rx_take && state_reg == S_BODY && type_reg == T_TXREQ
        && ofs_reg >= OFS_PAY && pcnt_reg != PAY_FULL) begin
      mem[pcnt_reg[PW-1:0]] <= rx_data;
    end
  end

  // ****
  // Packet and response outputs
  // ****
  assign pkt_valid = (state_reg == S_SEND);
  assign pkt_last = (16'(rd_reg) + 16'h0001 >= 16'(pcnt_reg));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pkt_data <= 8'h00;
      pkt_len <= 16'h0000;
      pkt_dest64 <= 64'h0;
      pkt_net16 <= 16'h0000;
      pkt_bcast <= 1'b0;
      pkt_coord <= 1'b0;
      pkt_resolve <= 1'b0;
      pkt_radius <= 8'h00;
      pkt_no_retry <= 1'b0;
      pkt_encrypt <= 1'b0;
      pkt_ext_timeout <= 1'b0;
      ext_dest_reg <= 64'h0;
    end else if (ce) begin
      if (state_reg == S_EXEC && type_reg == T_TXREQ) begin
        pkt_data <= mem[0];
        pkt_len <= 16'(pcnt_reg);
        pkt_dest64 <= dest_reg;
        pkt_net16 <= net_reg;
        pkt_bcast <= is_bcast;
        pkt_coord <= is_coord;
        pkt_resolve <= (net_reg == NET_UNKNOWN) && !is_bcast && !is_coord;
        // Above-maximum radius is clamped rather than refused
        if (!is_bcast) begin
          pkt_radius <= 8'h00;
        end else if (radius_reg == 8'h00 || radius_reg > hops_act_reg) begin
          pkt_radius <= hops_act_reg;
        end else begin
          pkt_radius <= radius_reg;
        end
        pkt_no_retry <= opts_reg[OPT_NO_RETRY];
        pkt_encrypt <= enc_req;
        pkt_ext_timeout <= opts_reg[OPT_EXT];
        if (opts_reg[OPT_EXT]) ext_dest_reg <= dest_reg;
      end else if (state_reg == S_SEND && pkt_ready) begin
        pkt_data <= mem[rd_reg[PW-1:0] + 1'b1];
      end
    end
  end

  assign resp_valid = (state_reg == S_RESP);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      resp_type <= 8'h00;
      resp_id <= 8'h00;
      resp_name <= 16'h0000;
      resp_status <= 8'h00;
      resp_value <= 32'h0000_0000;
      resp_net16 <= 16'h0000;
    end else if (ce) begin
      if (state_reg == S_EXEC) begin
        resp_id <= id_reg;
        resp_name <= name_reg;
        resp_net16 <= net_reg;
        resp_value <= has_val ? 32'h0000_0000 : qry_val;
        if (is_cmd) begin
          resp_type <= T_CMDRSP;
          resp_status <= cmd_status;
        end else begin
          resp_type <= T_TXSTAT;
          resp_status <= ST_TOO_BIG;
        end
      end else if (state_reg == S_WAIT && tx_done) begin
        resp_status <= tx_status;
        if (pkt_resolve) resp_net16 <= tx_net16;
      end
    end
  end

  // ****
  // Settings, active and pending
  // ****
  assign serial_rate = rate_act_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rate_act_reg <= RATE_RST;
      rate_pend_reg <= RATE_RST;
      hops_act_reg <= HOPS_RST;
      hops_pend_reg <= HOPS_RST;
      ee_act_reg <= 1'b0;
      ee_pend_reg <= 1'b0;
      maxpay_reg <= MAXPAY_RST;
      coord_reg <= COORD_RST;
      rx_en_reg <= 1'b1;
    end else if (ce) begin
      if (exec_cmd) begin
        // Immediate frame or apply command commits everything pending
        if (type_reg == T_CMD || name_reg == NM_APPLY) begin
          rate_act_reg <= rate_pend_reg;
          hops_act_reg <= hops_pend_reg;
          ee_act_reg <= ee_pend_reg;
        end
        if (has_val) begin
          unique case (name_reg)
            NM_RATE: begin
              rate_pend_reg <= val_reg[7:0];
              if (type_reg == T_CMD) rate_act_reg <= val_reg[7:0];
            end
            NM_HOPS: begin
              hops_pend_reg <= val_reg[7:0];
              if (type_reg == T_CMD) hops_act_reg <= val_reg[7:0];
            end
            NM_ENC: begin
              ee_pend_reg <= val_reg[0];
              if (type_reg == T_CMD) ee_act_reg <= val_reg[0];
            end
            default: ;
          endcase
        end
      end
      if (wr_pend_reg) begin
        unique case (waddr_reg)
          A_CTRL: rx_en_reg <= hwdata[0];
          A_HOPS: begin
            hops_act_reg <= hwdata[7:0];
            hops_pend_reg <= hwdata[7:0];
          end
          A_ENC: begin
            ee_act_reg <= hwdata[0];
            ee_pend_reg <= hwdata[0];
          end
          A_MAXPAY: maxpay_reg <= hwdata[15:0];
          A_COORD_HI: coord_reg[63:32] <= hwdata;
          A_COORD_LO: coord_reg[31:0] <= hwdata;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      good_cnt_reg <= 16'h0000;
      bad_cnt_reg <= 16'h0000;
    end else if (ce && rx_take && state_reg == S_CHK) begin
      if (8'(sum_reg + rx_data) == CHK_GOOD) begin
        good_cnt_reg <= good_cnt_reg + 16'h0001;
      end else begin
        bad_cnt_reg <= bad_cnt_reg + 16'h0001;
      end
    end
  end

  // ****
  // AHB-Lite slave
  // ****
  // Zero wait states; a low clock enable stretches the transfer
  assign hreadyout = ce;
  assign hresp = 1'b0;

  always_comb begin
    unique case (haddr[7:0])
      A_CTRL: rd_mux = {31'h0000_0000, rx_en_reg};
      A_RATE: rd_mux = {16'h0000, rate_pend_reg, rate_act_reg};
      A_HOPS: rd_mux = {24'h00_0000, hops_act_reg};
      A_ENC: rd_mux = {31'h0000_0000, ee_act_reg};
      A_MAXPAY: rd_mux = {16'h0000, maxpay_reg};
      A_COORD_HI: rd_mux = coord_reg[63:32];
      A_COORD_LO: rd_mux = coord_reg[31:0];
      A_EXT_HI: rd_mux = ext_dest_reg[63:32];
      A_EXT_LO: rd_mux = ext_dest_reg[31:0];
      A_COUNT: rd_mux = {bad_cnt_reg, good_cnt_reg};
      A_STATE: rd_mux = {28'h000_0000, state_reg};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      waddr_reg <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else if (ce) begin
      wr_pend_reg <= 1'b0;
      if (hsel && hready && htrans[1]) begin
        wr_pend_reg <= hwrite;
        waddr_reg <= haddr[7:0];
        if (!hwrite) hrdata <= rd_mux;
      end
    end
  end
endmodule : aqf_framer
`default_nettype wire

// ===== core/aqf_pkg.sv
// Constants and types shared by the serial frame interpreter
package aqf_pkg;
  // ****
  // Frame layout
  // ****
  localparam logic [7:0] DELIM = 8'h7E;
  localparam logic [7:0] CHK_GOOD = 8'hFF;
  localparam logic [7:0] T_CMD = 8'h08;
  localparam logic [7:0] T_QCMD = 8'h09;
  localparam logic [7:0] T_TXREQ = 8'h10;
  localparam logic [7:0] T_CMDRSP = 8'h88;
  localparam logic [7:0] T_TXSTAT = 8'h8B;
  localparam logic [15:0] OFS_TYPE = 16'h0003;
  localparam logic [15:0] OFS_ID = 16'h0004;
  localparam logic [15:0] OFS_NAME = 16'h0005;
  localparam logic [15:0] OFS_NAME_LO = 16'h0006;
  localparam logic [15:0] OFS_VAL = 16'h0007;
  localparam logic [15:0] OFS_DEST = 16'h0005;
  localparam logic [15:0] OFS_DEST_LO = 16'h000C;
  localparam logic [15:0] OFS_NET = 16'h000D;
  localparam logic [15:0] OFS_NET_LO = 16'h000E;
  localparam logic [15:0] OFS_RADIUS = 16'h000F;
  localparam logic [15:0] OFS_OPTS = 16'h0010;
  localparam logic [15:0] OFS_PAY = 16'h0011;
  localparam logic [15:0] LEN_TO_LAST = 16'h0002;
  localparam logic [63:0] ADDR_BCAST = 64'h0000_0000_0000_FFFF;
  localparam logic [63:0] ADDR_ZERO = 64'h0000_0000_0000_0000;
  localparam logic [15:0] NET_UNKNOWN = 16'hFFFE;
  localparam logic [15:0] NET_COORD = 16'h0000;
  localparam int OPT_NO_RETRY = 0;
  localparam int OPT_ENC = 5;
  localparam int OPT_EXT = 6;
  localparam logic [15:0] ENC_OVERHEAD = 16'h0004;
  localparam logic [2:0] VAL_MAX_BYTES = 3'h4;
  // ****
  // Parameter command names and status codes
  // ****
  localparam logic [15:0] NM_RATE = 16'h4244;
  localparam logic [15:0] NM_HOPS = 16'h4E48;
  localparam logic [15:0] NM_PAYLOAD = 16'h4E50;
  localparam logic [15:0] NM_ENC = 16'h4545;
  localparam logic [15:0] NM_APPLY = 16'h4143;
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_BADCMD = 8'h02;
  localparam logic [7:0] ST_BADPARM = 8'h03;
  localparam logic [7:0] ST_TOO_BIG = 8'h74;
  // ****
  // Register map and reset values
  // ****
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_RATE = 8'h04;
  localparam logic [7:0] A_HOPS = 8'h08;
  localparam logic [7:0] A_ENC = 8'h0C;
  localparam logic [7:0] A_MAXPAY = 8'h10;
  localparam logic [7:0] A_COORD_HI = 8'h14;
  localparam logic [7:0] A_COORD_LO = 8'h18;
  localparam logic [7:0] A_EXT_HI = 8'h1C;
  localparam logic [7:0] A_EXT_LO = 8'h20;
  localparam logic [7:0] A_COUNT = 8'h24;
  localparam logic [7:0] A_STATE = 8'h28;
  localparam logic [7:0] RATE_RST = 8'h03;
  localparam logic [7:0] HOPS_RST = 8'h1E;
  localparam logic [15:0] MAXPAY_RST = 16'h0054;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_LENH = 4'h1, S_LENL = 4'h2, S_BODY = 4'h3, S_CHK = 4'h4,
    S_EXEC = 4'h5, S_SEND = 4'h6, S_WAIT = 4'h7, S_RESP = 4'h8
  } aqf_state_t;
endpackage : aqf_pkg

// ===== tb/aqf_host.sv
// Host model: sends serial frames and takes responses
`timescale 1ns/100ps
`default_nettype none
module aqf_host import aqf_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic slow,
  input wire logic rx_ready,
  output var logic rx_valid,
  output var logic [7:0] rx_data,
  input wire logic resp_valid,
  output var logic resp_ready
);
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'hA5;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      resp_ready <= 1'b0;
    end else begin
      // Slow mode takes each response a cycle late
      resp_ready <= slow ? (resp_valid & ~resp_ready) : 1'b1;
    end
  end
  task automatic put(input logic [7:0] b);
    rx_valid <= 1'b1;
    rx_data <= b;
    do @(posedge hclk); while (rx_ready !== 1'b1);
  endtask : put
  task automatic send(input logic [7:0] d[$], input logic bad);
    logic [7:0] s;
    s = 8'h00;
    @(posedge hclk);
    put(DELIM);
    put(8'(d.size() >> 8));
    put(8'(d.size()));
    foreach (d[i]) begin
      put(d[i]);
      s = s + d[i];
    end
    put((CHK_GOOD - s) ^ {7'h0, bad});
    rx_valid <= 1'b0;
    // Idle line must not keep the last byte
    rx_data <= ~rx_data;
  endtask : send
endmodule : aqf_host
`default_nettype wire

// ===== tb/aqf_sva.sv
// Checker for the frame interpreter outputs
`timescale 1ns/100ps
`default_nettype none
module aqf_sva import aqf_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pkt_valid,
  input wire logic pkt_ready,
  input wire logic [7:0] pkt_data,
  input wire logic pkt_last,
  input wire logic [63:0] pkt_dest64,
  input wire logic [15:0] pkt_net16,
  input wire logic pkt_bcast,
  input wire logic pkt_coord,
  input wire logic pkt_resolve,
  input wire logic [7:0] pkt_radius,
  input wire logic resp_valid,
  input wire logic resp_ready,
  input wire logic [7:0] resp_type,
  input wire logic [7:0] resp_id
);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_rsp_id; resp_valid |-> resp_id != 8'h00; endproperty
  a_rsp_id: assert property (p_rsp_id) else $error("response with zero id");
  property p_rsp_type; resp_valid |-> resp_type == T_CMDRSP || resp_type == T_TXSTAT; endproperty
  a_rsp_type: assert property (p_rsp_type) else $error("bad response type");
  property p_rsp_hold; resp_valid && !resp_ready |=> resp_valid && $stable(resp_id); endproperty
  a_rsp_hold: assert property (p_rsp_hold) else $error("response dropped early");
  property p_bcast; pkt_valid |-> pkt_bcast == (pkt_dest64 == ADDR_BCAST); endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast flag wrong");
  property p_coord; pkt_valid && pkt_dest64 == ADDR_ZERO && pkt_net16 == NET_UNKNOWN |-> pkt_coord; endproperty
  a_coord: assert property (p_coord) else $error("coordinator not flagged");
  property p_resolve; pkt_valid && pkt_resolve |-> pkt_net16 == NET_UNKNOWN && !pkt_bcast; endproperty
  a_resolve: assert property (p_resolve) else $error("resolve on known address");
  property p_radius; pkt_valid && pkt_bcast |-> pkt_radius != 8'h00; endproperty
  a_radius: assert property (p_radius) else $error("broadcast radius zero");
  property p_beat; pkt_valid && !pkt_ready |=> pkt_valid && $stable(pkt_data) && $stable(pkt_dest64); endproperty
  a_beat: assert property (p_beat) else $error("beat changed while stalled");
  property p_one; pkt_valid && pkt_ready && pkt_last |=> !pkt_valid [*2]; endproperty
  a_one: assert property (p_one) else $error("packet beats after last");
  c_bcast: cover property (pkt_valid && pkt_ready && pkt_bcast);
  c_txstat: cover property (resp_valid && resp_ready && resp_type == T_TXSTAT);
  c_stall: cover property (resp_valid && !resp_ready ##1 resp_valid && resp_ready);
endmodule : aqf_sva
bind aqf_framer aqf_sva aqf_sva_i (.hclk, .hresetn, .pkt_valid, .pkt_ready, .pkt_data, .pkt_last, .pkt_dest64,
  .pkt_net16, .pkt_bcast, .pkt_coord, .pkt_resolve, .pkt_radius, .resp_valid, .resp_ready, .resp_type, .resp_id);
`default_nettype wire

// ===== tb/tb_top.sv
// Testbench for the frame interpreter
`timescale 1ns/100ps
`default_nettype none
module tb_top import aqf_pkg::*;;
  logic hclk = 1'b0, hresetn = 1'b0, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0, hready;
  logic pkt_ready = 1'b0, tx_done = 1'b0, slow = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, resp_value;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [7:0] tx_status = 8'h00, pkt_data, pkt_radius, resp_type, resp_id, resp_status, serial_rate, rx_data;
  logic [15:0] tx_net16 = 16'h0, pkt_len, pkt_net16, resp_net16, resp_name;
  logic [63:0] pkt_dest64;
  logic hreadyout, hresp, rx_valid, rx_ready, pkt_valid, pkt_last, pkt_bcast, pkt_coord, pkt_resolve;
  logic pkt_no_retry, pkt_encrypt, pkt_ext_timeout, resp_valid, resp_ready;
  logic [7:0] pq[$];
  logic [7:0] f[$];
  int err_count = 0, n_tests = 0;
  typedef struct {logic [7:0] ty; logic [15:0] nm; int nv; logic [31:0] v; logic [7:0] st;} aqf_row_t;
  aqf_row_t rows[7] = '{'{T_CMD, NM_HOPS, 1, 32'h5, ST_OK}, '{T_QCMD, NM_HOPS, 0, 32'h5, ST_OK},
    '{T_QCMD, NM_HOPS, 2, 32'hA, ST_OK}, '{T_QCMD, NM_HOPS, 0, 32'hA, ST_OK}, '{T_QCMD, NM_HOPS, 4, 32'hB, ST_OK},
    '{T_QCMD, NM_HOPS, 0, 32'hB, ST_OK}, '{T_CMD, 16'h5A5A, 0, 32'h0, ST_BADCMD}};
  assign hready = hreadyout;
  aqf_framer #(.PAY_DEPTH(32)) aqf_framer_i (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .rx_valid, .rx_data, .rx_ready, .pkt_valid, .pkt_data, .pkt_last,
    .pkt_ready, .pkt_len, .pkt_dest64, .pkt_net16, .pkt_bcast, .pkt_coord, .pkt_resolve, .pkt_radius,
    .pkt_no_retry, .pkt_encrypt, .pkt_ext_timeout, .tx_done, .tx_status, .tx_net16, .resp_valid, .resp_ready,
    .resp_type, .resp_id, .resp_name, .resp_status, .resp_value, .resp_net16, .serial_rate);
  aqf_host aqf_host_i (.hclk, .hresetn, .slow, .rx_ready, .rx_valid, .rx_data, .resp_valid, .resp_ready);
  initial begin
    forever #12.5 hclk = ~hclk;
  end
  // Network side stalls every other cycle
  always @(posedge hclk) begin
    pkt_ready <= ~pkt_ready;
    if (pkt_valid && pkt_ready) pq.push_back(pkt_data);
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_tests++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask : chk
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic wresp(input logic [7:0] ty, input logic [7:0] id, input logic [7:0] st);
    for (int k = 0; k < 400 && !(resp_valid && resp_ready); k++) @(negedge hclk);
    chk("resp_seen", 1, resp_valid && resp_ready);
    chk("resp", {ty, id, st}, {resp_type, resp_id, resp_status});
  endtask : wresp
  task automatic nores();
    logic s;
    s = 1'b0;
    repeat (60) @(negedge hclk) s |= resp_valid;
    chk("no_resp", 0, s);
  endtask : nores
  task automatic cmd(input logic [7:0] ty, id, input logic [15:0] nm, input int nv, input logic [31:0] v, bad);
    f = {ty, id, nm[15:8], nm[7:0]};
    for (int i = nv - 1; i >= 0; i--) f.push_back(v[8*i +: 8]);
    aqf_host_i.send(f, bad);
  endtask : cmd
  task automatic tx(input logic [63:0] d, input logic [15:0] nt, input logic [7:0] r, o, input int n);
    f = {T_TXREQ, 8'h02};
    for (int i = 7; i >= 0; i--) f.push_back(d[8*i +: 8]);
    f = {f, nt[15:8], nt[7:0], r, o};
    for (int i = 0; i < n; i++) f.push_back(8'(8'h31 + i));
    pq = {};
    aqf_host_i.send(f, 1'b0);
  endtask : tx
  task automatic pkt(input int n, input logic [15:0] net);
    for (int k = 0; k < 400 && pq.size() < n; k++) @(negedge hclk);
    chk("pkt_count", n, pq.size());
    foreach (pq[i]) chk("pkt_data", 8'h31 + i, pq[i]);
    chk("pkt_len", n, pkt_len);
    @(posedge hclk);
    tx_done <= 1'b1;
    tx_net16 <= net;
    @(posedge hclk);
    tx_done <= 1'b0;
    wresp(T_TXSTAT, 8'h02, ST_OK);
  endtask : pkt
  initial begin
    #(25 * 20000);
    err_count++;
    finish_test();
  end
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    chk("rate_rst", RATE_RST, serial_rate);
    ahb(1'b0, A_HOPS, 32'h0);
    chk("hops_rst", HOPS_RST, rd[7:0]);
    ahb(1'b0, A_MAXPAY, 32'h0);
    chk("maxpay_rst", MAXPAY_RST, rd[15:0]);
    ahb(1'b1, 8'h3C, 32'h5A5A);
    ahb(1'b0, 8'h3C, 32'h0);
    chk("unmapped", 32'h0, rd);
    $display("registers test done");
    foreach (rows[i]) begin
      slow <= 1'(i % 2);
      cmd(rows[i].ty, 8'(i + 1), rows[i].nm, rows[i].nv, rows[i].v, 1'b0);
      wresp(T_CMDRSP, 8'(i + 1), rows[i].st);
      chk("resp_name", rows[i].nm, resp_name);
      if (rows[i].nv == 0 && rows[i].st == ST_OK) chk("resp_value", rows[i].v, resp_value);
    end
    $display("table test done");
    cmd(T_QCMD, 8'h01, NM_RATE, 1, 32'h7, 1'b0);
    wresp(T_CMDRSP, 8'h01, ST_OK);
    chk("rate_held", RATE_RST, serial_rate);
    ahb(1'b0, A_RATE, 32'h0);
    chk("rate_reg", 16'h0703, rd[15:0]);
    cmd(T_CMD, 8'h03, NM_RATE, 1, 32'h5, 1'b1);
    nores();
    cmd(T_CMD, 8'h00, NM_APPLY, 0, 32'h0, 1'b0);
    nores();
    chk("rate_applied", 8'h07, serial_rate);
    $display("queued rate test done");
    tx(ADDR_BCAST, NET_UNKNOWN, 8'h00, 8'h01, 3);
    pkt(3, 16'h0);
    chk("bcast", {2'h3, 8'h0B}, {pkt_bcast, pkt_no_retry, pkt_radius});
    tx(64'h0011223344556677, NET_UNKNOWN, 8'h07, 8'h40, 2);
    pkt(2, 16'h1234);
    chk("found_net", 16'h1234, resp_net16);
    chk("unicast", {3'h3, 64'h0011223344556677}, {pkt_bcast, pkt_resolve, pkt_ext_timeout, pkt_dest64});
    ahb(1'b0, A_EXT_LO, 32'h0);
    chk("ext_dest", 32'h44556677, rd);
    tx(ADDR_ZERO, NET_UNKNOWN, 8'h00, 8'h00, 1);
    pkt(1, 16'h0);
    chk("coord", 2'h2, {pkt_coord, pkt_resolve});
    ahb(1'b1, A_ENC, 32'h1);
    ahb(1'b1, A_MAXPAY, 32'h5);
    tx(ADDR_BCAST, NET_UNKNOWN, 8'h00, 8'h20, 2);
    wresp(T_TXSTAT, 8'h02, ST_TOO_BIG);
    chk("no_pkt", 0, pq.size());
    tx(ADDR_BCAST, NET_UNKNOWN, 8'h00, 8'h20, 1);
    pkt(1, 16'h0);
    chk("encrypt", 1, pkt_encrypt);
    $display("transmit test done");
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
